// >>> src/vio_pkg.sv
package vio_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NUM_VIN = 5;
  localparam int NUM_VOUT = 5;
  localparam int NUM_AIN = 2;
  localparam int FUNC_W = 6;
  localparam int DELAY_W = 15;
  localparam int AIN_W = 10;
  localparam int EVT_W = 7;

  // ----------------------------------------
  // Function codes and ranges
  // ----------------------------------------
  localparam logic [5:0] VIN_FUNC_MAX = 6'h31;
  localparam logic [5:0] AIN_FUNC_MAX = 6'h31;
  localparam logic [5:0] VOUT_FUNC_MAX = 6'h26;
  localparam logic [5:0] VOUT_FUNC_MIRROR = 6'h00;
  localparam logic [5:0] FUNC_FWD = 6'h01;
  localparam logic [5:0] FUNC_USER_FAULT = 6'h2c;

  // ----------------------------------------
  // Analog thresholds, 10 mV per count
  // ----------------------------------------
  localparam logic [9:0] AIN_HIGH_LEVEL = 10'h2bc;
  localparam logic [9:0] AIN_LOW_LEVEL = 10'h12c;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_TIME_MS = 100;
  localparam int TICK_CYCLES = TICK_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [14:0] DELAY_MAX = 15'h7530;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_VIN_FUNC = 8'h00;
  localparam logic [7:0] OFF_VIN_SRC = 8'h04;
  localparam logic [7:0] OFF_VIN_STATE = 8'h08;
  localparam logic [7:0] OFF_AIN_FUNC = 8'h0c;
  localparam logic [7:0] OFF_AIN_LEVEL = 8'h10;
  localparam logic [7:0] OFF_VOUT_FUNC = 8'h14;
  localparam logic [7:0] OFF_VOUT_POL = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1c;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h20;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h24;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h28;
  localparam logic [7:0] OFF_VOUT_DLY0 = 8'h30;

  // ----------------------------------------
  // Status field positions and reset values
  // ----------------------------------------
  localparam int STS_VIN_LSB = 0;
  localparam int STS_VOUT_LSB = 8;
  localparam int STS_AIN_LSB = 16;
  localparam int STS_INIT_BIT = 24;
  localparam int EVT_AIN_LSB = 5;
  localparam logic [4:0] RST_BITS5 = 5'h00;
  localparam logic [5:0] RST_FUNC = 6'h00;
  localparam logic [14:0] RST_DELAY = 15'h0000;

endpackage

// >>> src/vio_out_delay.sv
`timescale 1ns/1ps

module vio_out_delay
  import vio_pkg::*;
(
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic tick, // 0.1 s enable pulse
  input wire logic raw, // Undelayed output state
  input wire logic [DELAY_W-1:0] delay, // Delay in 0.1 s steps
  input wire logic invert, // Negative logic select
  output logic level // Delayed, polarised state
);

  logic held;
  logic [DELAY_W-1:0] count;
  wire differs = raw != held;
  wire expired = count >= delay;

  // ----------------------------------------
  // Delay both edges, restart on glitch
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held <= 1'b0;
      count <= RST_DELAY;
    end else if (!differs) begin
      count <= RST_DELAY;
    end else if (expired) begin
      held <= raw;
      count <= RST_DELAY;
    end else if (tick) begin
      count <= count + 15'h0001;
    end
  end

  // Polarity after the delay stage
  assign level = held ^ invert;

endmodule

// >>> src/vio_terminal.sv
// Function
// - Five virtual inputs each select a function code 0 to 49, default 0.
// - Per-input source bit: 0 uses paired virtual output, 1 software state.
// - Virtual input x ties only to virtual output x.
// - Active tied output makes input active, applying its function like user fault.
// - After init completes, active forward-run input under terminal source starts running.
// - Each analog input selects a digital function code 0 to 49, default 0.
// - Analog reads high at or above 7 V, low at or below 3 V.
// - Between thresholds the analog digital state holds its last value.
// - Per analog level bit: 0 high active, 1 low active, third reserved.
// - Output function 0 mirrors physical input x onto virtual output x.
// - Output function 1 to 38 acts as physical output of that code.
// - Each virtual output delays 0.0 to 3000.0 s in 0.1 s steps.
// - Per-output polarity bit: 0 positive, 1 negative logic, default 0.
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps

module vio_terminal
  import vio_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  input wire logic pclk, // APB clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic [NUM_VIN-1:0] physical_input, // Board inputs, async
  input wire logic [AIN_W-1:0] analog_input_one, // Sampled code, 10 mV
  input wire logic [AIN_W-1:0] analog_input_two, // Sampled code, 10 mV
  input wire logic [VOUT_FUNC_MAX:0] do_func_state, // Output function states
  input wire logic init_done, // Power-on init finished
  input wire logic cmd_source_terminal, // Terminal command source
  output logic [NUM_VIN-1:0] virtual_input, // Virtual input active
  output logic [NUM_VIN*FUNC_W-1:0] virtual_input_func, // Codes per input
  output logic [NUM_AIN-1:0] analog_active, // Analog used as input
  output logic [NUM_AIN*FUNC_W-1:0] analog_func, // Codes per analog
  output logic [NUM_VOUT-1:0] virtual_output, // Virtual output state
  output logic forward_run_cmd, // Forward run request
  output logic user_fault_code, // User fault request
  output logic irq // Level interrupt
);

  if (TICK_DIV < 1) begin : g_bad_div
    $error("TICK_DIV must be at least one");
  end

  localparam int TW = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;

  // ----------------------------------------
  // Configuration state
  // ----------------------------------------
  logic [FUNC_W-1:0] vin_func [NUM_VIN];
  logic [NUM_VIN-1:0] vin_src;
  logic [NUM_VIN-1:0] vin_state;
  logic [FUNC_W-1:0] ain_func [NUM_AIN];
  logic [NUM_AIN-1:0] ain_level;
  logic [FUNC_W-1:0] vout_func [NUM_VOUT];
  logic [NUM_VOUT-1:0] vout_pol;
  logic [DELAY_W-1:0] vout_dly [NUM_VOUT];
  logic [EVT_W-1:0] irq_status;
  logic [EVT_W-1:0] irq_enable;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire setup = psel && !penable;
  wire wr_acc = psel && penable && pwrite;
  wire hit_vin_func = paddr == OFF_VIN_FUNC;
  wire hit_vin_src = paddr == OFF_VIN_SRC;
  wire hit_vin_state = paddr == OFF_VIN_STATE;
  wire hit_ain_func = paddr == OFF_AIN_FUNC;
  wire hit_ain_level = paddr == OFF_AIN_LEVEL;
  wire hit_vout_func = paddr == OFF_VOUT_FUNC;
  wire hit_vout_pol = paddr == OFF_VOUT_POL;
  wire hit_status = paddr == OFF_STATUS;
  wire hit_irq_status = paddr == OFF_IRQ_STATUS;
  wire hit_irq_clear = paddr == OFF_IRQ_CLEAR;
  wire hit_irq_enable = paddr == OFF_IRQ_ENABLE;
  wire [7:0] dly_rel = paddr - OFF_VOUT_DLY0;
  wire hit_dly = paddr >= OFF_VOUT_DLY0 && dly_rel[1:0] == 2'b00
                 && dly_rel[7:2] < 6'(NUM_VOUT);
  wire [2:0] dly_idx = dly_rel[4:2];
  wire addr_hit = hit_vin_func || hit_vin_src || hit_vin_state
                  || hit_ain_func || hit_ain_level || hit_vout_func
                  || hit_vout_pol || hit_status || hit_irq_status
                  || hit_irq_clear || hit_irq_enable || hit_dly;

  // Out-of-range codes refuse the whole write
  logic [NUM_VIN-1:0] vin_bad;
  logic [NUM_AIN-1:0] ain_bad;
  logic [NUM_VOUT-1:0] vout_bad;
  genvar g;
  generate
    for (g = 0; g < NUM_VIN; g++) begin : g_vin_chk
      assign vin_bad[g] = pwdata[g*FUNC_W +: FUNC_W] > VIN_FUNC_MAX;
      assign vout_bad[g] = pwdata[g*FUNC_W +: FUNC_W] > VOUT_FUNC_MAX;
    end
    for (g = 0; g < NUM_AIN; g++) begin : g_ain_chk
      assign ain_bad[g] = pwdata[g*FUNC_W +: FUNC_W] > AIN_FUNC_MAX;
    end
  endgenerate

  wire dly_bad = pwdata[DELAY_W-1:0] > DELAY_MAX || |pwdata[31:DELAY_W];
  wire wr_bad = (hit_vin_func && |vin_bad) || (hit_ain_func && |ain_bad)
                || (hit_vout_func && |vout_bad) || (hit_dly && dly_bad)
                || hit_status || hit_irq_status;
  wire wr_ok = wr_acc && addr_hit && !wr_bad;

  assign pready = 1'b1;
  assign pslverr = psel && penable && (!addr_hit || (pwrite && wr_bad));

  // ----------------------------------------
  // Configuration writes
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vin_src <= RST_BITS5;
      vin_state <= RST_BITS5;
      ain_level <= 2'b00;
      vout_pol <= RST_BITS5;
      irq_enable <= 7'h00;
    end else if (wr_ok) begin
      if (hit_vin_src) begin
        vin_src <= pwdata[NUM_VIN-1:0];
      end
      if (hit_vin_state) begin
        vin_state <= pwdata[NUM_VIN-1:0];
      end
      if (hit_ain_level) begin
        ain_level <= pwdata[NUM_AIN-1:0];
      end
      if (hit_vout_pol) begin
        vout_pol <= pwdata[NUM_VOUT-1:0];
      end
      if (hit_irq_enable) begin
        irq_enable <= pwdata[EVT_W-1:0];
      end
    end
  end

  generate
    for (g = 0; g < NUM_VIN; g++) begin : g_cfg5
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          vin_func[g] <= RST_FUNC;
          vout_func[g] <= RST_FUNC;
          vout_dly[g] <= RST_DELAY;
        end else if (wr_ok) begin
          if (hit_vin_func) begin
            vin_func[g] <= pwdata[g*FUNC_W +: FUNC_W];
          end
          if (hit_vout_func) begin
            vout_func[g] <= pwdata[g*FUNC_W +: FUNC_W];
          end
          if (hit_dly && dly_idx == 3'(g)) begin
            vout_dly[g] <= pwdata[DELAY_W-1:0];
          end
        end
      end
      assign virtual_input_func[g*FUNC_W +: FUNC_W] = vin_func[g];
    end
    for (g = 0; g < NUM_AIN; g++) begin : g_cfg2
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ain_func[g] <= RST_FUNC;
        end else if (wr_ok && hit_ain_func) begin
          ain_func[g] <= pwdata[g*FUNC_W +: FUNC_W];
        end
      end
      assign analog_func[g*FUNC_W +: FUNC_W] = ain_func[g];
    end
  endgenerate

  // ----------------------------------------
  // Input synchroniser and 0.1 s tick
  // ----------------------------------------
  logic [NUM_VIN-1:0] phys_meta;
  logic [NUM_VIN-1:0] phys_sync;
  logic [TW-1:0] tick_cnt;
  logic tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phys_meta <= RST_BITS5;
      phys_sync <= RST_BITS5;
    end else begin
      phys_meta <= physical_input;
      phys_sync <= phys_meta;
    end
  end

  wire tick_wrap = tick_cnt == TW'(TICK_DIV - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick_cnt <= tick_wrap ? '0 : tick_cnt + 1'b1;
      tick <= tick_wrap;
    end
  end

  // ----------------------------------------
  // Virtual outputs
  // ----------------------------------------
  logic [NUM_VOUT-1:0] vout_raw;

  generate
    for (g = 0; g < NUM_VOUT; g++) begin : g_vout
      wire mirror = vout_func[g] == VOUT_FUNC_MIRROR;
      assign vout_raw[g] = mirror ? phys_sync[g]
                                  : do_func_state[vout_func[g]];
      vio_out_delay u_dly (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick),
        .raw(vout_raw[g]),
        .delay(vout_dly[g]),
        .invert(vout_pol[g]),
        .level(virtual_output[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // Virtual inputs
  // ----------------------------------------
  // Held inactive until init completes, so no function fires early
  wire [NUM_VIN-1:0] vin_pick = (vin_src & vin_state)
                                | (~vin_src & virtual_output);
  wire [NUM_VIN-1:0] next_vin = init_done ? vin_pick : RST_BITS5;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      virtual_input <= RST_BITS5;
    end else begin
      virtual_input <= next_vin;
    end
  end

  // ----------------------------------------
  // Analog inputs used as digital
  // ----------------------------------------
  logic [NUM_AIN-1:0] ain_state;
  wire [AIN_W-1:0] ain_code [NUM_AIN];
  assign ain_code[0] = analog_input_one;
  assign ain_code[1] = analog_input_two;

  generate
    for (g = 0; g < NUM_AIN; g++) begin : g_ain
      wire above = ain_code[g] >= AIN_HIGH_LEVEL;
      wire below = ain_code[g] <= AIN_LOW_LEVEL;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ain_state[g] <= 1'b0;
        end else if (above) begin
          ain_state[g] <= 1'b1;
        end else if (below) begin
          ain_state[g] <= 1'b0;
        end
      end // Otherwise held
    end
  endgenerate

  wire [NUM_AIN-1:0] next_ain = init_done ? (ain_state ^ ain_level) : 2'b00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_active <= 2'b00;
    end else begin
      analog_active <= next_ain;
    end
  end

  // ----------------------------------------
  // Function requests
  // ----------------------------------------
  logic [NUM_VIN-1:0] vin_fwd;
  logic [NUM_VIN-1:0] vin_fault;
  logic [NUM_AIN-1:0] ain_fwd;
  logic [NUM_AIN-1:0] ain_fault;

  generate
    for (g = 0; g < NUM_VIN; g++) begin : g_vin_fn
      assign vin_fwd[g] = virtual_input[g] && vin_func[g] == FUNC_FWD;
      assign vin_fault[g] = virtual_input[g] && vin_func[g] == FUNC_USER_FAULT;
    end
    for (g = 0; g < NUM_AIN; g++) begin : g_ain_fn
      assign ain_fwd[g] = analog_active[g] && ain_func[g] == FUNC_FWD;
      assign ain_fault[g] = analog_active[g] && ain_func[g] == FUNC_USER_FAULT;
    end
  endgenerate

  wire next_fwd = cmd_source_terminal && (|vin_fwd || |ain_fwd);
  wire next_fault = |vin_fault || |ain_fault;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      forward_run_cmd <= 1'b0;
      user_fault_code <= 1'b0;
    end else begin
      forward_run_cmd <= next_fwd;
      user_fault_code <= next_fault;
    end
  end

  // ----------------------------------------
  // Interrupt events
  // ----------------------------------------
  logic [NUM_VIN-1:0] vin_prev;
  logic [NUM_AIN-1:0] ain_prev;
  wire [NUM_VIN-1:0] vin_rise = virtual_input & ~vin_prev;
  wire [NUM_AIN-1:0] ain_chg = analog_active ^ ain_prev;
  wire [EVT_W-1:0] events = {ain_chg, vin_rise};
  wire [EVT_W-1:0] clr = (wr_acc && hit_irq_clear) ? pwdata[EVT_W-1:0] : 7'h00;

  // Set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vin_prev <= RST_BITS5;
      ain_prev <= 2'b00;
      irq_status <= 7'h00;
    end else begin
      vin_prev <= virtual_input;
      ain_prev <= analog_active;
      irq_status <= (irq_status & ~clr) | events;
    end
  end

  assign irq = |(irq_status & irq_enable);

  // ----------------------------------------
  // Read data, captured in the setup phase
  // ----------------------------------------
  logic [31:0] status_word;
  logic [31:0] vin_func_word;
  logic [31:0] ain_func_word;
  logic [31:0] vout_func_word;
  logic [31:0] rd_mux;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[STS_VIN_LSB +: NUM_VIN] = virtual_input;
    status_word[STS_VOUT_LSB +: NUM_VOUT] = virtual_output;
    status_word[STS_AIN_LSB +: NUM_AIN] = analog_active;
    status_word[STS_INIT_BIT] = init_done;
  end

  assign vin_func_word = {2'b00, virtual_input_func};
  assign ain_func_word = {20'h00000, analog_func};
  assign vout_func_word = {2'b00, vout_func[4], vout_func[3], vout_func[2],
                           vout_func[1], vout_func[0]};

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_vin_func) begin
      rd_mux = vin_func_word;
    end else if (hit_vin_src) begin
      rd_mux[NUM_VIN-1:0] = vin_src;
    end else if (hit_vin_state) begin
      rd_mux[NUM_VIN-1:0] = vin_state;
    end else if (hit_ain_func) begin
      rd_mux = ain_func_word;
    end else if (hit_ain_level) begin
      rd_mux[NUM_AIN-1:0] = ain_level;
    end else if (hit_vout_func) begin
      rd_mux = vout_func_word;
    end else if (hit_vout_pol) begin
      rd_mux[NUM_VOUT-1:0] = vout_pol;
    end else if (hit_status) begin
      rd_mux = status_word;
    end else if (hit_irq_status) begin
      rd_mux[EVT_W-1:0] = irq_status;
    end else if (hit_irq_enable) begin
      rd_mux[EVT_W-1:0] = irq_enable;
    end else if (hit_dly) begin
      rd_mux[DELAY_W-1:0] = vout_dly[dly_idx];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= rd_mux;
    end
  end

endmodule

// >>> testbench/vio_terminal_asserts.sv
`timescale 1ns/1ps

module vio_terminal_asserts
  import vio_pkg::*;
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic psel, // APB
  input wire logic penable, // APB
  input wire logic pwrite, // APB
  input wire logic [7:0] paddr, // APB
  input wire logic [31:0] pwdata, // APB
  input wire logic [31:0] prdata, // APB
  input wire logic pready, // APB
  input wire logic pslverr, // APB
  input wire logic [AIN_W-1:0] analog_input_one, // Analog code
  input wire logic init_done, // Init done
  input wire logic cmd_source_terminal, // Terminal source
  input wire logic [NUM_VIN-1:0] virtual_input, // Input state
  input wire logic [NUM_VIN*FUNC_W-1:0] virtual_input_func, // Codes
  input wire logic forward_run_cmd, // Run request
  input wire logic user_fault_code, // Fault request
  input wire logic [NUM_AIN*FUNC_W-1:0] analog_func, // Analog codes
  input wire logic [NUM_AIN-1:0] analog_active // Analog state
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ------
  // Helpers
  // ------
  function automatic logic over(input logic [29:0] w, input logic [5:0] mx);
    logic r;
    r = 1'h0;
    for (int i = 0; i < 5; i++) begin
      r = r | (w[6*i+:6] > mx);
    end
    return r;
  endfunction

  function automatic logic act(input logic [29:0] w, input logic [4:0] v, input logic [5:0] c);
    logic r;
    r = 1'h0;
    for (int i = 0; i < 5; i++) begin
      r = r | (v[i] && w[6*i+:6] == c);
    end
    return r;
  endfunction

  wire logic acc = psel && penable;
  wire logic fwd_hit = act(virtual_input_func, virtual_input, FUNC_FWD)
                       || act({18'h0, analog_func}, {3'h0, analog_active}, FUNC_FWD);
  wire logic flt_hit = act(virtual_input_func, virtual_input, FUNC_USER_FAULT)
                       || act({18'h0, analog_func}, {3'h0, analog_active}, FUNC_USER_FAULT);
  wire logic ain_hi = analog_input_one >= AIN_HIGH_LEVEL && !pwrite;
  wire logic ain_mid = analog_input_one > AIN_LOW_LEVEL && analog_input_one < AIN_HIGH_LEVEL && !pwrite;

  // ------
  // Properties
  // ------
  property p_vin_range;
    !over(virtual_input_func, VIN_FUNC_MAX);
  endproperty
  a_vin_range: assert property (p_vin_range) else $error("input code above range");

  property p_vin_refuse;
    acc && pwrite && paddr == OFF_VIN_FUNC && over(pwdata[29:0], VIN_FUNC_MAX) |-> pslverr;
  endproperty
  a_vin_refuse: assert property (p_vin_refuse) else $error("bad input code accepted");

  property p_vout_refuse;
    acc && pwrite && paddr == OFF_VOUT_FUNC && over(pwdata[29:0], VOUT_FUNC_MAX) |-> pslverr;
  endproperty
  a_vout_refuse: assert property (p_vout_refuse) else $error("bad output code accepted");

  property p_init;
    !init_done |=> virtual_input == 5'h00;
  endproperty
  a_init: assert property (p_init) else $error("input active before init");

  property p_fwd;
    forward_run_cmd == $past(cmd_source_terminal && fwd_hit);
  endproperty
  a_fwd: assert property (p_fwd) else $error("run request without cause");

  property p_fault;
    user_fault_code == $past(flt_hit);
  endproperty
  a_fault: assert property (p_fault) else $error("fault request without cause");

  // Four cycles span the two-stage analog pipeline
  property p_ain_hi;
    ain_hi [*4] |-> $stable(analog_active[0]);
  endproperty
  a_ain_hi: assert property (p_ain_hi) else $error("analog state moved while high");

  property p_ain_hold;
    ain_mid [*4] |-> $stable(analog_active[0]);
  endproperty
  a_ain_hold: assert property (p_ain_hold) else $error("analog state moved in band");

  property p_err;
    pslverr |-> acc && pready;
  endproperty
  a_err: assert property (p_err) else $error("error outside access");

  property p_clr;
    acc && !pwrite && paddr == OFF_IRQ_CLEAR |-> prdata == 32'h0 && !pslverr;
  endproperty
  a_clr: assert property (p_clr) else $error("clear register read not zero");

  c_fault: cover property (user_fault_code);
  c_fwd: cover property (forward_run_cmd);
  c_refuse: cover property (acc && pslverr);
endmodule

bind vio_terminal vio_terminal_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .analog_input_one(analog_input_one),
  .init_done(init_done), .cmd_source_terminal(cmd_source_terminal), .virtual_input(virtual_input),
  .virtual_input_func(virtual_input_func), .forward_run_cmd(forward_run_cmd), .analog_func(analog_func),
  .user_fault_code(user_fault_code), .analog_active(analog_active)
);

// >>> testbench/vio_terminal_tb.sv
`timescale 1ns/1ps

module vio_terminal_tb;
  import vio_pkg::*;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic init_done = 1'h0, cmd_source_terminal = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [4:0] physical_input = 5'h00;
  logic [9:0] analog_input_one = 10'h000, analog_input_two = 10'h000;
  logic [38:0] do_func_state = 39'h0;
  logic [31:0] prdata, rd, v;
  logic pready, pslverr, err, forward_run_cmd, user_fault_code, irq, st;
  logic [4:0] virtual_input, virtual_output;
  logic [29:0] virtual_input_func;
  logic [1:0] analog_active;
  logic [11:0] analog_func;
  logic [9:0] av [6] = '{10'h320, 10'h1f4, 10'h12c, 10'h2bb, 10'h2bc, 10'h12d};
  int failures = 0, tests_run = 0, seed = 45;

  vio_terminal #(.TICK_DIV(10)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .physical_input(physical_input),
    .analog_input_one(analog_input_one), .analog_input_two(analog_input_two), .do_func_state(do_func_state),
    .init_done(init_done), .cmd_source_terminal(cmd_source_terminal), .virtual_input(virtual_input),
    .virtual_input_func(virtual_input_func), .analog_active(analog_active), .analog_func(analog_func),
    .virtual_output(virtual_output), .forward_run_cmd(forward_run_cmd), .user_fault_code(user_fault_code),
    .irq(irq)
  );

  initial begin
    forever #20 pclk = ~pclk;
  end

  // ------
  // Tasks
  // ------
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    tests_run++;
    if (got !== ex) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Idle edge first so no signal is driven twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    pwrite <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    apb(1'h1, a, d);
    chk("pslverr", {31'h0, ee}, {31'h0, err});
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] ex, input logic ee);
    apb(1'h0, a, 32'h0);
    chk("prdata", ex, rd);
    chk("pslverr", {31'h0, ee}, {31'h0, err});
  endtask

  task automatic wt(input logic b);
    for (int n = 0; n < 40 && virtual_output[0] !== b; n++) begin
      @(posedge pclk);
    end
  endtask

  task automatic finish_test;
    $display("tests_run %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  function automatic logic f_ain(input logic prev, input logic [9:0] c);
    return c >= AIN_HIGH_LEVEL ? 1'h1 : (c <= AIN_LOW_LEVEL ? 1'h0 : prev);
  endfunction

  // ------
  // Scenarios
  // ------
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    for (int a = 0; a <= 8'h44; a += 4) begin
      rdc(a[7:0], 32'h0, a == 8'h2c || a == 8'h44);
    end
    wr(OFF_VIN_FUNC, 32'h32, 1'h1);
    wr(OFF_VIN_FUNC, {2'h0, {5{6'h31}}}, 1'h0);
    wr(OFF_AIN_FUNC, 32'hc80, 1'h1);
    wr(OFF_VOUT_FUNC, 32'h27, 1'h1);
    wr(OFF_VOUT_DLY0, 32'h7531, 1'h1);
    wr(OFF_VOUT_DLY0 + 8'h04, 32'h7530, 1'h0);
    rdc(OFF_VOUT_DLY0 + 8'h04, 32'h7530, 1'h0);
    wr(OFF_VOUT_DLY0 + 8'h04, 32'h0, 1'h0);
    wr(OFF_STATUS, 32'hffffffff, 1'h1);
    v = $random(seed);
    wr(OFF_AIN_FUNC, {20'h0, v[11:6] & 6'h1f, v[5:0] & 6'h1f}, 1'h0);
    cyc(2);
    chk("ain_func", {20'h0, v[11:6] & 6'h1f, v[5:0] & 6'h1f}, {20'h0, analog_func});
    chk("vin_func", {2'h0, {5{6'h31}}}, {2'h0, virtual_input_func});
    $display("test regs done");
    repeat (6) begin
      v = $random(seed);
      wr(OFF_VOUT_POL, {27'h0, v[4:0]}, 1'h0);
      physical_input <= v[9:5];
      cyc(5);
      chk("vout", {27'h0, v[9:5] ^ v[4:0]}, {27'h0, virtual_output});
    end
    wr(OFF_VOUT_POL, 32'h0, 1'h0);
    for (int k = 1; k <= 38; k++) begin
      wr(OFF_VOUT_FUNC, {2'h0, {5{k[5:0]}}}, 1'h0);
      v = $random(seed);
      do_func_state <= {v[6:0], $random(seed)};
      cyc(4);
      chk("vout_fn", {27'h0, {5{do_func_state[k]}}}, {27'h0, virtual_output});
    end
    wr(OFF_VOUT_FUNC, 32'h0, 1'h0);
    $display("test outputs done");
    wr(OFF_VIN_FUNC, 32'h2c, 1'h0);
    physical_input <= 5'h00;
    init_done <= 1'h1;
    cyc(6);
    wr(OFF_IRQ_CLEAR, 32'h7f, 1'h0);
    physical_input <= 5'h04;
    cyc(6);
    chk("irq_masked", 32'h0, {31'h0, irq});
    rdc(OFF_IRQ_STATUS, 32'h4, 1'h0);
    wr(OFF_IRQ_ENABLE, 32'h4, 1'h0);
    cyc(1);
    chk("irq_on", 32'h1, {31'h0, irq});
    wr(OFF_IRQ_CLEAR, 32'h4, 1'h0);
    cyc(1);
    chk("irq_off", 32'h0, {31'h0, irq});
    rdc(OFF_IRQ_STATUS, 32'h0, 1'h0);
    repeat (6) begin
      v = $random(seed);
      physical_input <= v[4:0];
      cyc(7);
      chk("vin", {27'h0, v[4:0]}, {27'h0, virtual_input});
      chk("fault", {31'h0, v[0]}, {31'h0, user_fault_code});
    end
    rdc(OFF_STATUS, {7'h0, 1'h1, 11'h0, v[4:0], 3'h0, v[4:0]}, 1'h0);
    $display("test tie done");
    wr(OFF_VIN_SRC, 32'h1f, 1'h0);
    wr(OFF_VIN_FUNC, 32'h01, 1'h0);
    for (int i = 0; i < 8; i++) begin
      v = i == 0 ? 32'h3f : $random(seed);
      st = i != 3;
      wr(OFF_VIN_STATE, {27'h0, v[4:0]}, 1'h0);
      cmd_source_terminal <= v[5];
      init_done <= st;
      cyc(4);
      chk("vin_sw", {27'h0, v[4:0] & {5{st}}}, {27'h0, virtual_input});
      chk("fwd", {31'h0, v[0] & v[5] & st}, {31'h0, forward_run_cmd});
    end
    $display("test software state done");
    v = $random(seed);
    st = 1'h0;
    wr(OFF_AIN_LEVEL, {30'h0, v[1:0]}, 1'h0);
    for (int i = 0; i < 6; i++) begin
      analog_input_one <= av[i];
      analog_input_two <= av[i];
      st = f_ain(st, av[i]);
      cyc(4);
      chk("ain", {30'h0, {2{st}} ^ v[1:0]}, {30'h0, analog_active});
    end
    $display("test analog done");
    physical_input <= 5'h00;
    wr(OFF_VOUT_DLY0, 32'h3, 1'h0);
    physical_input <= 5'h01;
    cyc(15);
    chk("dly_rise_hold", 32'h0, {31'h0, virtual_output[0]});
    wt(1'h1);
    chk("dly_rise", 32'h1, {31'h0, virtual_output[0]});
    physical_input <= 5'h00;
    cyc(15);
    chk("dly_fall_hold", 32'h1, {31'h0, virtual_output[0]});
    wt(1'h0);
    chk("dly_fall", 32'h0, {31'h0, virtual_output[0]});
    wr(OFF_VOUT_POL, 32'h1, 1'h0);
    cyc(3);
    chk("pol_after_dly", 32'h1, {31'h0, virtual_output[0]});
    $display("test delay done");
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    finish_test();
  end
endmodule
